// *** fcs_defs.svh ***
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
// bus command codes
`define FCS_D_UNLOCK1     8'haa
`define FCS_D_UNLOCK2     8'h55
`define FCS_D_ID_ENTRY    8'h90
`define FCS_D_PROG_SETUP  8'ha0
`define FCS_D_ERASE_SETUP 8'h80
`define FCS_D_CHIP_ERASE  8'h10
`define FCS_D_SECT_ERASE  8'h30
`define FCS_D_SUSPEND     8'hb0
`define FCS_D_RESUME      8'h30
`define FCS_D_RESET       8'hf0
// unlock addresses, plus the don't-care address for single-cycle commands
`define FCS_A_UNLOCK1     22'h000555
`define FCS_A_UNLOCK2     22'h0002aa
`define FCS_A_ANY         22'h000000
// identification read offsets
`define FCS_A_ID_MAKER    22'h000000
`define FCS_A_ID_PART     22'h000001
`define FCS_A_ID_GROUP    22'h000002
// status line positions
`define FCS_BIT_POLL      7
`define FCS_BIT_TOGGLE1   6
`define FCS_BIT_TIMEOUT   5
// strobe timing in clock cycles (10 ns each)
`define FCS_T_SETUP_NS    30
`define FCS_T_SETUP_CYC   ((`FCS_T_SETUP_NS + 9) / 10)
`define FCS_T_PULSE_NS    50
`define FCS_T_PULSE_CYC   ((`FCS_T_PULSE_NS + 9) / 10)
`define FCS_T_ACCESS_NS   80
`define FCS_T_ACCESS_CYC  ((`FCS_T_ACCESS_NS + 9) / 10)
`endif

// *** fcs_pkg.sv ***
package fcs_pkg;
  // host command kinds
  typedef enum logic [3:0] {
    FCS_OP_READ    = 4'h0,
    FCS_OP_RESET   = 4'h1,
    FCS_OP_ID_READ = 4'h2,
    FCS_OP_PROGRAM = 4'h3,
    FCS_OP_CHIP_ER = 4'h4,
    FCS_OP_SECT_ER = 4'h5,
    FCS_OP_SUSPEND = 4'h6,
    FCS_OP_RESUME  = 4'h7,
    FCS_OP_SECT_ADD= 4'h8
  } fcs_op_t;

  // one user request
  typedef struct packed {
    fcs_op_t     op;
    logic [21:0] addr;
    logic [7:0]  data;
  } fcs_req_t;

  // one bus cycle handed to the strobe engine
  typedef struct packed {
    logic        wr;
    logic [21:0] addr;
    logic [7:0]  data;
  } fcs_cyc_t;

  // pins toward the flash
  typedef struct packed {
    logic [21:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
  } fcs_pins_t;
endpackage : fcs_pkg

// *** fcs_bus_cycle.sv ***
`timescale 1ns/1ns
`include "fcs_defs.svh"
// strobe engine: runs one read or write bus cycle on the flash pins
module fcs_bus_cycle
  import fcs_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire logic      start_i,
  input  wire fcs_cyc_t  cyc_i,
  input  wire logic [7:0] dq_sync_i,
  output fcs_pins_t      pins_o,
  output logic           done_o,
  output logic [7:0]     rdata_o
);
  typedef enum logic [3:0] {
    BC_IDLE  = 4'b0001,
    BC_SETUP = 4'b0010,
    BC_PULSE = 4'b0100,
    BC_HOLD  = 4'b1000
  } fcs_bc_state_t;

  fcs_bc_state_t state, next_state;
  fcs_pins_t     next_pins;
  logic [3:0]    cnt, next_cnt;
  logic [7:0]    next_rdata;
  logic          next_done;

  // address set up first, then we or oe low; write data leaves after we rises
  always_comb begin
    next_state = state;
    next_pins  = pins_o;
    next_cnt   = cnt;
    next_rdata = rdata_o;
    next_done  = 1'b0;
    case (state)
      BC_IDLE: begin
        if (start_i) begin
          next_pins.addr   = cyc_i.addr;
          next_pins.dq_out = cyc_i.data;
          next_pins.dq_oe  = cyc_i.wr;
          next_pins.ce_n   = 1'b0;
          next_cnt         = 4'(`FCS_T_SETUP_CYC);
          next_state       = BC_SETUP;
        end
      end
      BC_SETUP: begin
        if (cnt <= 4'h1) begin
          next_pins.we_n = ~pins_o.dq_oe;
          next_pins.oe_n = pins_o.dq_oe;
          next_cnt       = pins_o.dq_oe ? 4'(`FCS_T_PULSE_CYC) : 4'(`FCS_T_ACCESS_CYC + 2);
          next_state     = BC_PULSE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      BC_PULSE: begin
        if (cnt <= 4'h1) begin
          next_rdata     = dq_sync_i; // two stages late, covered by the longer pulse
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_state     = BC_HOLD;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      BC_HOLD: begin
        next_pins.ce_n  = 1'b1;
        next_pins.dq_oe = 1'b0;
        next_done       = 1'b1;
        next_state      = BC_IDLE;
      end
      default: next_state = BC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= BC_IDLE;
      pins_o  <= '{addr: 22'h0, dq_out: 8'h0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      cnt     <= 4'h0;
      rdata_o <= 8'h0;
      done_o  <= 1'b0;
    end else begin
      state   <= next_state;
      pins_o  <= next_pins;
      cnt     <= next_cnt;
      rdata_o <= next_rdata;
      done_o  <= next_done;
    end
  end

  a_we_oe_excl: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(!pins_o.we_n && !pins_o.oe_n)) else $error("write and output strobes low together");
  a_we_has_ce: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pins_o.we_n |-> !pins_o.ce_n && pins_o.dq_oe) else $error("write strobe without chip strobe");
  a_data_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(pins_o.we_n) |-> $stable(pins_o.dq_out) && $stable(pins_o.addr)) else $error("data moved at strobe rise");
endmodule : fcs_bus_cycle

// *** fcs_host.sv ***
`timescale 1ns/1ns
`include "fcs_defs.svh"
module fcs_host
  import fcs_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_valid_i,
  input  wire fcs_req_t    req_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_data_o,
  output logic             rsp_timeout_o,
  output logic             busy_o,
  output logic [21:0]      flash_addr_o,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe_o,
  input  wire logic [7:0]  flash_dq_i,
  output logic             flash_ce_n_o,
  output logic             flash_we_n_o,
  output logic             flash_oe_n_o,
  input  wire logic        ready_busy_output_i
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_CYC  = 5'b00010,
    H_WAIT = 5'b00100,
    H_RSP  = 5'b01000,
    H_RST  = 5'b10000
  } fcs_h_state_t;

  fcs_h_state_t state, next_state;
  fcs_req_t     cur, next_cur;
  logic [2:0]   idx, next_idx;
  logic [2:0]   last, next_last;
  logic         start, next_start;
  logic [7:0]   rdata_hold, next_rdata_hold;
  logic         tmo, next_tmo;
  fcs_cyc_t     cyc;
  fcs_pins_t    pins;
  logic         cyc_done;
  logic [7:0]   cyc_rdata;
  logic [7:0]   dq_s1, dq_s2;
  logic         rb_s1, rb_s2;

  // pins from the device pass two flops before anything looks at them
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1 <= 8'h0;
      dq_s2 <= 8'h0;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= flash_dq_i;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_output_i;
      rb_s2 <= rb_s1;
    end
  end

  // the bus cycle for step idx of the current command
  always_comb begin
    cyc.wr   = 1'b1;
    cyc.addr = `FCS_A_UNLOCK1;
    cyc.data = `FCS_D_UNLOCK1;
    case (cur.op)
      FCS_OP_READ: begin
        cyc.wr   = 1'b0;
        cyc.addr = cur.addr;
      end
      FCS_OP_RESET: begin
        cyc.addr = `FCS_A_ANY;
        cyc.data = `FCS_D_RESET;
      end
      FCS_OP_SUSPEND: begin
        cyc.addr = `FCS_A_ANY;
        cyc.data = `FCS_D_SUSPEND;
      end
      FCS_OP_RESUME: begin
        cyc.addr = `FCS_A_ANY;
        cyc.data = `FCS_D_RESUME;
      end
      FCS_OP_SECT_ADD: begin
        cyc.addr = {cur.addr[21:16], 16'h0000};
        cyc.data = `FCS_D_SECT_ERASE;
      end
      default: begin
        // unlock prefix shared by identification, program and both erases
        if (idx == 3'd1 || idx == 3'd4) begin
          cyc.addr = `FCS_A_UNLOCK2;
          cyc.data = `FCS_D_UNLOCK2;
        end else if (idx == 3'd2) begin
          cyc.data = (cur.op == FCS_OP_ID_READ) ? `FCS_D_ID_ENTRY :
                     (cur.op == FCS_OP_PROGRAM) ? `FCS_D_PROG_SETUP : `FCS_D_ERASE_SETUP;
        end else if (idx == 3'd3 && cur.op == FCS_OP_ID_READ) begin
          cyc.wr   = 1'b0;
          cyc.addr = cur.addr;
        end else if (idx == 3'd3 && cur.op == FCS_OP_PROGRAM) begin
          cyc.addr = cur.addr;
          cyc.data = cur.data;
        end else if (idx == 3'd5) begin
          cyc.addr = (cur.op == FCS_OP_CHIP_ER) ? `FCS_A_UNLOCK1 : {cur.addr[21:16], 16'h0000};
          cyc.data = (cur.op == FCS_OP_CHIP_ER) ? `FCS_D_CHIP_ERASE : `FCS_D_SECT_ERASE;
        end
      end
    endcase
  end

  // command sequencer; unlock cycles drive zero on high address bits
  always_comb begin
    next_state      = state;
    next_cur        = cur;
    next_idx        = idx;
    next_last       = last;
    next_start      = 1'b0;
    next_rdata_hold = rdata_hold;
    next_tmo        = tmo;
    case (state)
      H_IDLE: begin
        if (req_valid_i) begin
          next_cur   = req_i;
          next_idx   = 3'd0;
          next_tmo   = 1'b0;
          next_start = 1'b1;
          case (req_i.op)
            FCS_OP_ID_READ, FCS_OP_PROGRAM: next_last = 3'd3;
            FCS_OP_CHIP_ER, FCS_OP_SECT_ER: next_last = 3'd5;
            default:                        next_last = 3'd0;
          endcase
          next_state = H_CYC;
        end
      end
      H_CYC: begin
        if (cyc_done) begin
          if (idx == last) begin
            next_rdata_hold = cyc_rdata;
            next_state      = H_WAIT;
          end else begin
            next_idx   = idx + 3'd1;
            next_start = 1'b1;
          end
        end
      end
      H_WAIT: begin
        // a status read with the time-limit bit high while busy gets an automatic reset;
        // the released bus is not a second status read, so only the busy line qualifies it
        if (!cyc.wr && rdata_hold[`FCS_BIT_TIMEOUT] && rb_s2 == 1'b0) begin
          next_tmo   = 1'b1;
          next_state = H_RST;
        end else begin
          next_state = H_RSP;
        end
      end
      H_RST: begin
        next_cur.op = FCS_OP_RESET;
        next_idx    = 3'd0;
        next_last   = 3'd0;
        next_start  = 1'b1;
        next_state  = H_CYC;
      end
      H_RSP: next_state = H_IDLE;
      default: next_state = H_IDLE;
    endcase
    if (state == H_CYC && cyc_done && idx == last && cur.op == FCS_OP_RESET && tmo)
      next_state = H_RSP;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= H_IDLE;
      cur        <= '{op: FCS_OP_READ, addr: 22'h0, data: 8'h0};
      idx        <= 3'd0;
      last       <= 3'd0;
      start      <= 1'b0;
      rdata_hold <= 8'h0;
      tmo        <= 1'b0;
    end else begin
      state      <= next_state;
      cur        <= next_cur;
      idx        <= next_idx;
      last       <= next_last;
      start      <= next_start;
      rdata_hold <= next_rdata_hold;
      tmo        <= next_tmo;
    end
  end

  fcs_bus_cycle u_cycle (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start),
    .cyc_i     (cyc),
    .dq_sync_i (dq_s2),
    .pins_o    (pins),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata)
  );

  // pin and user outputs
  assign flash_addr_o  = pins.addr;
  assign flash_dq_o    = pins.dq_out;
  assign flash_dq_oe_o = pins.dq_oe;
  assign flash_ce_n_o  = pins.ce_n;
  assign flash_we_n_o  = pins.we_n;
  assign flash_oe_n_o  = pins.oe_n;
  assign req_ready_o   = (state == H_IDLE);
  assign rsp_valid_o   = (state == H_RSP);
  assign rsp_data_o    = rdata_hold;
  assign rsp_timeout_o = tmo;
  assign busy_o        = ~rb_s2;

  a_rsp_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rsp_valid_o |=> !rsp_valid_o && req_ready_o) else $error("response held too long");
  a_suspend_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && cur.op == FCS_OP_SUSPEND |-> flash_dq_o == 8'hb0) else $error("bad suspend");
  a_resume_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && cur.op == FCS_OP_RESUME |-> flash_dq_o == 8'h30) else $error("bad resume");
  a_reset_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && cur.op == FCS_OP_RESET |-> flash_dq_o == 8'hf0) else $error("bad reset");
  a_unlock_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && idx == 3'd0 && last != 3'd0 |-> flash_addr_o == 22'h000555 &&
    flash_dq_o == 8'haa) else $error("bad first unlock");
  a_unlock_second: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && idx == 3'd1 && last != 3'd0 |-> flash_addr_o == 22'h0002aa &&
    flash_dq_o == 8'h55) else $error("bad second unlock");
  a_prog_target: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && idx == 3'd3 && cur.op == FCS_OP_PROGRAM |->
    flash_addr_o == cur.addr && flash_dq_o == cur.data) else $error("bad program target");
  a_sector_cmd: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) && idx == 3'd5 && cur.op == FCS_OP_SECT_ER |->
    flash_dq_o == 8'h30 && flash_addr_o[15:0] == 16'h0) else $error("bad sector command");
  a_tmo_resets: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == H_RST |=> state == H_CYC && cur.op == FCS_OP_RESET) else $error("no reset");
  a_read_no_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cur.op == FCS_OP_READ && state == H_CYC |-> flash_we_n_o) else $error("read wrote");
  c_program: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    rsp_valid_o && cur.op == FCS_OP_PROGRAM);
  c_sect_erase: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    rsp_valid_o && cur.op == FCS_OP_SECT_ER);
  c_suspend: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    rsp_valid_o && cur.op == FCS_OP_SUSPEND);
  c_timeout: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    rsp_valid_o && tmo);
endmodule : fcs_host

// *** fcs_flash_model.sv ***
`timescale 1ns/1ns
`include "fcs_defs.svh"
// behavioural flash: command decoder, array and embedded timers, driven by strobe edges
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary identity value
  parameter logic [7:0] PART_CODE  = 8'h3c, // arbitrary identity value
  parameter int         PROG_NS    = 2000,
  parameter int         ERASE_NS   = 30000,
  parameter int         SUSP_NS    = 9000,
  parameter int         COLLECT_NS = 50000
) (
  input  wire logic [21:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        fail_i,
  output logic [7:0]       dq_o,
  output logic             rb_low_o
);
  logic [7:0]  mem [logic [21:0]];
  logic [21:0] erased [$];
  logic [63:0] er_sect = '0;
  logic [21:0] la;
  logic [21:0] pa;
  logic [7:0]  pd;
  logic [7:0]  rd = 8'hff;
  logic        id_md = 0, susp = 0, sq = 0, pbusy = 0, ebusy = 0, chip = 0, coll = 0;
  logic        fl = 0, tog = 0;
  int          st = 0, pt = 0, et = 0, ct = 0, qt = 0;

  // address at the falling write strobe, data at its rising edge; the chip strobe only gates both
  always @(negedge we_n_i) if (!ce_n_i) la = addr_i;
  always @(posedge we_n_i) if (!ce_n_i) decode(la, dq_i);

  // read value is fixed at the start of the read; released lines show its inverse
  always @(negedge oe_n_i) begin
    tog = ~tog;
    rd = rd_val(addr_i);
  end
  assign dq_o     = (!ce_n_i && !oe_n_i) ? rd : ~rd;
  assign rb_low_o = pbusy || (ebusy && !susp);

  function automatic logic [7:0] rd_val(logic [21:0] a);
    if (pbusy) return {~pd[7], tog, fl, 5'h00};
    // every group reads as unprotected
    if (id_md) return a[7:0] == 8'h00 ? MAKER_CODE : a[7:0] == 8'h01 ? PART_CODE : 8'h00;
    if (ebusy && (!susp || er_sect[a[21:16]])) return {susp, tog & !susp, 2'b00, !coll, tog, 2'b00};
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd_val

  // one coarse timebase; 100 ns grain is far finer than any figure checked
  always #100 begin
    if (pbusy && !fl) pt += 100;
    if (pbusy && !fl && pt >= PROG_NS) begin
      mem[pa] = (mem.exists(pa) ? mem[pa] : 8'hff) & pd;
      pbusy = 0;
    end
    if (ebusy && !susp && coll) ct += 100;
    if (ebusy && !susp && coll && ct >= COLLECT_NS) coll = 0;
    if (ebusy && !susp && !coll) et += 100;
    if (ebusy && !susp && !coll && et >= ERASE_NS) begin
      erased.delete();
      foreach (mem[k]) if (chip || er_sect[k[21:16]]) erased.push_back(k);
      foreach (erased[i]) mem.delete(erased[i]);
      ebusy = 0;
    end
    if (sq) qt += 100;
    if (sq && qt >= SUSP_NS) begin
      susp = 1;
      sq = 0;
    end
  end

  task automatic decode(logic [21:0] a, logic [7:0] d);
    logic lo5, lo2;
    lo5 = a[10:0] == 11'h555;
    lo2 = a[10:0] == 11'h2aa;
    if (d == `FCS_D_RESET && (!pbusy || fl)) begin
      id_md = 0;
      fl = 0;
      pbusy = 0;
      st = 0;
    end else if (pbusy || (ebusy && chip)) begin
      st = 0; // embedded algorithm runs on, suspend included
    end else if (ebusy && !susp) begin
      if (d == `FCS_D_SUSPEND && coll) begin
        susp = 1; // address ignored
        coll = 0; // window closes now, so a resume starts the erase itself
      end
      else if (d == `FCS_D_SUSPEND) sq = 1;
      else if (coll && d == `FCS_D_SECT_ERASE) er_sect[a[21:16]] = 1;
      else if (coll) ebusy = 0;
      ct = 0;
      qt = 0;
    end else if (susp && st == 0 && d == `FCS_D_RESUME) begin
      susp = 0; // repeats find no suspension and fall through
    end else begin
      case (st)
        0: st = (lo5 && d == `FCS_D_UNLOCK1) ? 1 : 0;
        1: st = (lo2 && d == `FCS_D_UNLOCK2) ? 2 : 0;
        2: begin
          st = (lo5 && d == `FCS_D_PROG_SETUP) ? 3 : (lo5 && d == `FCS_D_ERASE_SETUP && !susp) ? 4 : 0;
          if (lo5 && d == `FCS_D_ID_ENTRY) id_md = 1;
        end
        3: begin
          pa = a;
          pd = d;
          pt = 0;
          pbusy = 1;
          fl = fail_i;
          st = 0;
        end
        4: st = (lo5 && d == `FCS_D_UNLOCK1) ? 5 : 0;
        5: st = (lo2 && d == `FCS_D_UNLOCK2) ? 6 : 0;
        default: begin
          chip = lo5 && d == `FCS_D_CHIP_ERASE;
          ebusy = chip || d == `FCS_D_SECT_ERASE;
          er_sect = chip ? '1 : 64'h1 << a[21:16];
          coll = !chip;
          et = 0;
          st = 0;
        end
      endcase
    end
  endtask : decode
endmodule : fcs_flash_model

// *** fcs_host_test.sv ***
`timescale 1ns/1ns
`include "fcs_defs.svh"
// host controller against the flash model, random programs plus suspend corner cases
module fcs_host_test
  import fcs_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary identity value
  localparam logic [7:0] PART  = 8'h3c; // arbitrary identity value
  logic        mclk_i = 0, rst_n_i = 0, req_valid_i = 0, fail = 0;
  fcs_req_t    req_i = '0;
  logic        req_ready_o, rsp_valid_o, rsp_timeout_o, busy_o, rb_low, ready_busy_output_i;
  logic        flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o;
  logic [7:0]  rsp_data_o, flash_dq_o, flash_dq_i, mdq, rd, r1;
  logic [21:0] flash_addr_o, a;
  logic [31:0] seed = 32'h00007211;
  logic [31:0] r;
  logic [7:0]  em [logic [21:0]];
  logic [21:0] pa_q [$];
  int          miscompares = 0, compares = 0, cyc = 0;

  // ready line is open drain with a pull-up; host owns dq only while enabled
  assign ready_busy_output_i = !rb_low;
  assign flash_dq_i          = flash_dq_oe_o ? flash_dq_o : mdq;

  fcs_host dut_u (.mclk_i, .rst_n_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o,
    .rsp_data_o, .rsp_timeout_o, .busy_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o,
    .flash_dq_i, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o, .ready_busy_output_i);
  fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (.addr_i(flash_addr_o),
    .dq_i(flash_dq_o), .ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o),
    .fail_i(fail), .dq_o(mdq), .rb_low_o(rb_low));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // hang guard, about four times the expected run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] exp_rd(logic [21:0] ad);
    return em.exists(ad) ? em[ad] : 8'hff;
  endfunction : exp_rd
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request held from a falling edge until a rising edge sees ready
  task automatic req(fcs_op_t op, logic [21:0] ad, logic [7:0] d);
    int k;
    k = 0;
    @(negedge mclk_i);
    req_valid_i = 1;
    req_i = '{op, ad, d};
    while (req_ready_o !== 1'b1) @(negedge mclk_i);
    @(negedge mclk_i);
    req_valid_i = 0;
    while (rsp_valid_o !== 1'b1 && k < 500) begin
      @(negedge mclk_i);
      k++;
    end
    chk({7'h0, rsp_valid_o}, 8'h01);
    rd = rsp_data_o;
  endtask : req
  task automatic wait_busy(logic v, int lim);
    for (int n = 0; n < lim && busy_o !== v; n++) @(negedge mclk_i);
  endtask : wait_busy
  task automatic rd_chk(logic [21:0] ad);
    req(FCS_OP_READ, ad, 8'h00);
    chk(rd, exp_rd(ad));
  endtask : rd_chk
  task automatic prog(logic [21:0] ad, logic [7:0] d);
    req(FCS_OP_PROGRAM, ad, d);
    req(FCS_OP_READ, ad, 8'h00);
    chk({7'h0, rd[7]}, {7'h0, ~d[7]});
    em[ad] = exp_rd(ad) & d;
    wait_busy(1'b0, 1000);
    rd_chk(ad);
  endtask : prog
  task automatic done_t(string s);
    $display("test %0s finished", s);
  endtask : done_t
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5) @(negedge mclk_i);
    chk({7'h0, req_ready_o & flash_we_n_o & flash_ce_n_o}, 8'h01);
    rst_n_i = 1;
    done_t("reset");
    repeat (6) begin
      r = xs();
      a = {6'h05, r[15:0]};
      pa_q.push_back(a);
      prog(a, r[23:16]);
    end
    prog(pa_q[0], 8'hff);
    done_t("program");
    req(FCS_OP_ID_READ, `FCS_A_ID_MAKER, 8'h00);
    chk(rd, MAKER);
    req(FCS_OP_READ, `FCS_A_ID_PART | 22'h3f0000, 8'h00);
    chk(rd, PART);
    req(FCS_OP_READ, `FCS_A_ID_GROUP | 22'h2c0000, 8'h00);
    chk(rd, 8'h00);
    req(FCS_OP_RESET, 22'h000000, 8'h00);
    rd_chk(pa_q[1]);
    done_t("identify");
    req(FCS_OP_SUSPEND, 22'h000000, 8'h00);
    rd_chk(pa_q[3]);
    a = pa_q[4];
    req(FCS_OP_PROGRAM, a, 8'h0f);
    req(FCS_OP_SUSPEND, a, 8'h00);
    em[a] = exp_rd(a) & 8'h0f;
    wait_busy(1'b0, 1000);
    rd_chk(a);
    done_t("suspend_ignored");
    a = 22'h030010;
    prog(a, 8'h12);
    req(FCS_OP_SECT_ER, 22'h030000, 8'h00);
    req(FCS_OP_SECT_ADD, 22'h090000, 8'h00);
    r = xs();
    req(FCS_OP_SUSPEND, r[21:0], 8'h00);
    wait_busy(1'b0, 20);
    chk({7'h0, busy_o}, 8'h00);
    req(FCS_OP_READ, a, 8'h00);
    r1 = rd;
    req(FCS_OP_READ, 22'h09abcd, 8'h00);
    chk({5'h0, rd[7:6], rd[2]}, {5'h0, 1'b1, r1[6], ~r1[2]});
    rd_chk(pa_q[1]);
    r = xs();
    prog({6'h07, r[15:0]}, r[23:16]);
    req(FCS_OP_ID_READ, 22'h030000, 8'h00);
    chk(rd, MAKER);
    req(FCS_OP_RESET, 22'h000000, 8'h00);
    req(FCS_OP_READ, a, 8'h00);
    chk({7'h0, rd[7]}, 8'h01);
    req(FCS_OP_RESUME, r[21:0], 8'h00);
    wait_busy(1'b1, 20);
    chk({7'h0, busy_o}, 8'h01);
    req(FCS_OP_RESUME, 22'h000000, 8'h00);
    repeat (300) @(negedge mclk_i);
    chk({7'h0, busy_o}, 8'h01);
    req(FCS_OP_SUSPEND, 22'h3fffff, 8'h00);
    wait_busy(1'b0, 2000);
    chk({7'h0, busy_o}, 8'h00);
    req(FCS_OP_READ, a, 8'h00);
    chk({7'h0, rd[7]}, 8'h01);
    req(FCS_OP_RESUME, 22'h000000, 8'h00);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 5000);
    em.delete(a);
    rd_chk(a);
    rd_chk(pa_q[2]);
    done_t("sector_suspend");
    req(FCS_OP_CHIP_ER, 22'h000000, 8'h00);
    req(FCS_OP_SUSPEND, 22'h000000, 8'h00);
    wait_busy(1'b0, 50);
    chk({7'h0, busy_o}, 8'h01);
    wait_busy(1'b0, 5000);
    em.delete();
    rd_chk(pa_q[5]);
    done_t("chip_erase");
    fail = 1;
    a = pa_q[3];
    req(FCS_OP_PROGRAM, a, 8'h00);
    fail = 0;
    req(FCS_OP_READ, a, 8'h00);
    chk({7'h0, rsp_timeout_o}, 8'h01);
    wait_busy(1'b0, 100);
    rd_chk(a);
    chk({7'h0, rsp_timeout_o}, 8'h00);
    done_t("time_limit");
    finish_test();
  end
endmodule : fcs_host_test
